/* File: pmcb_bank.v */
`timescale 1ns/1ps
`default_nettype none
`include "pmcb_map.vh"
module pmcb_bank #(
	parameter EE_AW = 8,
	parameter INFO_VALUE = 16'h1234 // arbitrary value
) (
	input wire SYS_CLK_I,
	input wire RESET_I,
	input wire CMD_WR_I,
	input wire CMD_RD_I,
	input wire CMD_SEND_I,
	input wire [7:0] CMD_CODE_I,
	input wire CMD_PAGE_I,
	input wire [15:0] CMD_WDATA_I,
	output reg [15:0] CMD_RDATA_O,
	output reg CMD_RVALID_O,
	output reg CMD_ACK_O,
	input wire TEL_VALID_I,
	input wire TEL_CHAN_I,
	input wire [15:0] TEL_IOUT_I,
	input wire [15:0] TEL_VOUT_I,
	input wire [15:0] TEL_VIN_I,
	input wire [15:0] TEL_TEMP_I,
	input wire ADC_CONV_VALID_I,
	input wire [7:0] ADC_CONV_ID_I,
	input wire [15:0] PAD_LEVELS_I,
	input wire STORE_ALL_I,
	input wire RESTORE_ALL_I,
	output wire NV_STORE_O,
	output wire NV_RESTORE_O,
	output reg EE_ERASE_O,
	output reg EE_WR_O,
	output reg EE_RD_O,
	output reg [EE_AW-1:0] EE_ADDR_O,
	output reg [15:0] EE_WDATA_O,
	input wire [15:0] EE_RDATA_I,
	output reg CML_RO_WRITE_O,
	output wire [6:0] BUS_ADDR_O,
	output wire [7:0] FAST_ADC_SEL_O,
	output wire [15:0] FLT_PROP0_O,
	output wire [15:0] FLT_PROP1_O,
	output wire [15:0] RETRY0_O,
	output wire [15:0] RETRY1_O,
	output wire [15:0] RESTART0_O,
	output wire [15:0] RESTART1_O
);
	// real value of a linear word on a fixed-point grid with sixteen fraction
	// bits; that depth keeps the most negative exponent exact, and 64 bits hold
	// the largest positive exponent without wrapping
	function signed [63:0] l11_scaled;
		input [15:0] w;
		reg signed [63:0] man;
		reg [4:0] mag;
		begin
			man = {{(64 - `PMCB_MAN_HI - 1){w[`PMCB_MAN_HI]}}, w[`PMCB_MAN_HI:0]};
			// a negative exponent shifts right by its magnitude
			mag = ~w[`PMCB_EXP_HI:`PMCB_EXP_LO] + 5'h01;
			if (w[`PMCB_EXP_HI])
				l11_scaled = (man <<< `PMCB_L11_FRAC) >>> mag;
			else
				l11_scaled = (man <<< `PMCB_L11_FRAC) <<< w[`PMCB_EXP_HI-1:`PMCB_EXP_LO];
		end
	endfunction

	// peak compare by real value, so words with different exponents order correctly
	function l11_gt;
		input [15:0] a;
		input [15:0] b;
		begin
			l11_gt = l11_scaled(a) > l11_scaled(b);
		end
	endfunction

	// maker and user words; paged ones are held once per channel
	reg [15:0] oem_a;
	reg [15:0] oem_b;
	reg [15:0] tool_w0;
	reg [15:0] tool_w1;
	reg [15:0] spare_p0;
	reg [15:0] spare_p1;
	reg [15:0] spare_g;

	// byte-wide option and control registers
	reg [7:0] chan_opt0;
	reg [7:0] chan_opt1;
	reg [7:0] glob_opt;
	reg [7:0] pwm0;
	reg [7:0] pwm1;
	reg [7:0] fact0;
	reg [7:0] fact1;
	reg [7:0] adc_sel;
	reg [7:0] adc_stat;
	reg [7:0] addr;

	// per-channel fault propagation and timing words
	reg [15:0] prop0;
	reg [15:0] prop1;
	reg [15:0] retry0;
	reg [15:0] retry1;
	reg [15:0] restart0;
	reg [15:0] restart1;

	// peak trackers; input voltage is shared by both channels
	reg [15:0] ipk0;
	reg [15:0] ipk1;
	reg [15:0] vpk0;
	reg [15:0] vpk1;
	reg [15:0] vinpk;
	reg [15:0] tpk0;
	reg [15:0] tpk1;

	// eeprom gate state and the pending eeprom read
	reg unlocked;
	reg [EE_AW-1:0] ee_ptr;
	reg rd_pend;

	// command strobes and page select
	wire wr = CMD_WR_I;
	wire p = CMD_PAGE_I;
	wire clr = CMD_SEND_I && (CMD_CODE_I == `PMCB_CMD_CLR_PK);
	// codes that only answer reads; a write to one is flagged and dropped
	wire ro_hit = (CMD_CODE_I == `PMCB_CMD_INFO) ||
		(CMD_CODE_I == `PMCB_CMD_OT_ACT) ||
		(CMD_CODE_I == `PMCB_CMD_IOUT_PK) ||
		(CMD_CODE_I == `PMCB_CMD_VOUT_PK) ||
		(CMD_CODE_I == `PMCB_CMD_VIN_PK) ||
		(CMD_CODE_I == `PMCB_CMD_TEMP_PK) ||
		(CMD_CODE_I == `PMCB_CMD_PADS);

	// address and fast adc selection go straight out of their flops
	assign BUS_ADDR_O = addr[6:0];
	assign FAST_ADC_SEL_O = adc_sel;
	// fault propagation and restart timing feed the sequencer per channel
	assign FLT_PROP0_O = prop0;
	assign FLT_PROP1_O = prop1;
	assign RETRY0_O = retry0;
	assign RETRY1_O = retry1;
	assign RESTART0_O = restart0;
	assign RESTART1_O = restart1;
	// store/restore handled by the nvm engine outside; bank just relays
	assign NV_STORE_O = STORE_ALL_I;
	assign NV_RESTORE_O = RESTORE_ALL_I;

	// writable registers; writes to read-only codes fall through untouched
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			oem_a <= `PMCB_RST_ZERO16;
			oem_b <= `PMCB_RST_ZERO16;
			tool_w0 <= `PMCB_RST_ZERO16;
			tool_w1 <= `PMCB_RST_ZERO16;
			spare_p0 <= `PMCB_RST_ZERO16;
			spare_p1 <= `PMCB_RST_ZERO16;
			spare_g <= `PMCB_RST_ZERO16;
			chan_opt0 <= `PMCB_RST_CHAN_OPT;
			chan_opt1 <= `PMCB_RST_CHAN_OPT;
			glob_opt <= `PMCB_RST_GLOB_OPT;
			prop0 <= `PMCB_RST_FLT_PROP;
			prop1 <= `PMCB_RST_FLT_PROP;
			pwm0 <= `PMCB_RST_PWM_CFG;
			pwm1 <= `PMCB_RST_PWM_CFG;
			fact0 <= `PMCB_RST_FLT_ACT;
			fact1 <= `PMCB_RST_FLT_ACT;
			adc_sel <= `PMCB_RST_ZERO8;
			retry0 <= `PMCB_RST_RETRY;
			retry1 <= `PMCB_RST_RETRY;
			restart0 <= `PMCB_RST_RESTART;
			restart1 <= `PMCB_RST_RESTART;
			addr <= `PMCB_RST_ADDR;
		end else if (wr) begin
			// paged registers pick their copy from the page bit
			case (CMD_CODE_I)
			`PMCB_CMD_OEM_A: oem_a <= CMD_WDATA_I;
			`PMCB_CMD_OEM_B: oem_b <= CMD_WDATA_I;
			`PMCB_CMD_TOOL: begin
				if (p) tool_w1 <= CMD_WDATA_I;
				else tool_w0 <= CMD_WDATA_I;
			end
			`PMCB_CMD_SPARE_P: begin
				if (p) spare_p1 <= CMD_WDATA_I;
				else spare_p0 <= CMD_WDATA_I;
			end
			`PMCB_CMD_SPARE_G: spare_g <= CMD_WDATA_I;
			`PMCB_CMD_CHAN_OPT: begin
				if (p) chan_opt1 <= CMD_WDATA_I[7:0];
				else chan_opt0 <= CMD_WDATA_I[7:0];
			end
			`PMCB_CMD_GLOB_OPT: glob_opt <= CMD_WDATA_I[7:0];
			`PMCB_CMD_FLT_PROP: begin
				if (p) prop1 <= CMD_WDATA_I;
				else prop0 <= CMD_WDATA_I;
			end
			`PMCB_CMD_PWM_CFG: begin
				if (p) pwm1 <= CMD_WDATA_I[7:0];
				else pwm0 <= CMD_WDATA_I[7:0];
			end
			`PMCB_CMD_FLT_ACT: begin
				if (p) fact1 <= CMD_WDATA_I[7:0];
				else fact0 <= CMD_WDATA_I[7:0];
			end
			`PMCB_CMD_ADC_SEL: adc_sel <= CMD_WDATA_I[7:0];
			`PMCB_CMD_RETRY: begin
				if (p) retry1 <= CMD_WDATA_I;
				else retry0 <= CMD_WDATA_I;
			end
			`PMCB_CMD_RESTART: begin
				if (p) restart1 <= CMD_WDATA_I;
				else restart0 <= CMD_WDATA_I;
			end
			`PMCB_CMD_ADDR: addr <= CMD_WDATA_I[7:0] & `PMCB_ADDR_MASK;
			default: ;
			endcase
		end
	end

	// fast adc status follows the converter; a host write is also allowed
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I)
			adc_stat <= `PMCB_RST_ZERO8;
		// a host write in the same cycle loses to the converter
		else if (ADC_CONV_VALID_I)
			adc_stat <= ADC_CONV_ID_I;
		else if (wr && CMD_CODE_I == `PMCB_CMD_ADC_STAT)
			adc_stat <= CMD_WDATA_I[7:0];
	end

	// peak trackers; clear wins over a same-cycle sample so tracking restarts clean
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ipk0 <= `PMCB_PK_L11_FLOOR;
			ipk1 <= `PMCB_PK_L11_FLOOR;
			vpk0 <= `PMCB_PK_L16_FLOOR;
			vpk1 <= `PMCB_PK_L16_FLOOR;
			vinpk <= `PMCB_PK_L11_FLOOR;
			tpk0 <= `PMCB_PK_L11_FLOOR;
			tpk1 <= `PMCB_PK_L11_FLOOR;
		end else if (clr) begin
			// every tracker drops to its floor together
			ipk0 <= `PMCB_PK_L11_FLOOR;
			ipk1 <= `PMCB_PK_L11_FLOOR;
			vpk0 <= `PMCB_PK_L16_FLOOR;
			vpk1 <= `PMCB_PK_L16_FLOOR;
			vinpk <= `PMCB_PK_L11_FLOOR;
			tpk0 <= `PMCB_PK_L11_FLOOR;
			tpk1 <= `PMCB_PK_L11_FLOOR;
		end else if (TEL_VALID_I) begin
			// per-channel peaks follow the channel tag of the sample
			if (TEL_CHAN_I) begin
				if (l11_gt(TEL_IOUT_I, ipk1)) ipk1 <= TEL_IOUT_I;
				if (TEL_VOUT_I > vpk1) vpk1 <= TEL_VOUT_I;
				if (l11_gt(TEL_TEMP_I, tpk1)) tpk1 <= TEL_TEMP_I;
			end else begin
				if (l11_gt(TEL_IOUT_I, ipk0)) ipk0 <= TEL_IOUT_I;
				if (TEL_VOUT_I > vpk0) vpk0 <= TEL_VOUT_I;
				if (l11_gt(TEL_TEMP_I, tpk0)) tpk0 <= TEL_TEMP_I;
			end
			// the input supply is common, so every sample feeds one tracker
			if (l11_gt(TEL_VIN_I, vinpk)) vinpk <= TEL_VIN_I;
		end
	end

	// eeprom gate: unlock by byte write, erase resets pointer, data walks it
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			unlocked <= 1'b0;
			ee_ptr <= {EE_AW{1'b0}};
			EE_ERASE_O <= 1'b0;
			EE_WR_O <= 1'b0;
			EE_RD_O <= 1'b0;
			EE_ADDR_O <= {EE_AW{1'b0}};
			EE_WDATA_O <= `PMCB_RST_ZERO16;
		end else begin
			EE_ERASE_O <= 1'b0;
			EE_WR_O <= 1'b0;
			EE_RD_O <= 1'b0;
			// unlock holds until reset; there is no relock command
			if (wr && CMD_CODE_I == `PMCB_CMD_EE_UNLOCK) begin
				unlocked <= 1'b1;
			end else if (wr && CMD_CODE_I == `PMCB_CMD_EE_ERASE && unlocked) begin
				EE_ERASE_O <= 1'b1;
				ee_ptr <= {EE_AW{1'b0}};
			end else if (CMD_CODE_I == `PMCB_CMD_EE_DATA && unlocked && (wr || CMD_RD_I)) begin
				// one word per access; the pointer wraps at the top of the array
				EE_WR_O <= wr;
				EE_RD_O <= CMD_RD_I;
				EE_ADDR_O <= ee_ptr;
				EE_WDATA_O <= CMD_WDATA_I;
				ee_ptr <= ee_ptr + 1'b1;
			end
		end
	end

	// read mux, one cycle; eeprom data arrives a cycle later
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			CMD_RDATA_O <= `PMCB_RST_ZERO16;
			CMD_RVALID_O <= 1'b0;
			CMD_ACK_O <= 1'b0;
			CML_RO_WRITE_O <= 1'b0;
			rd_pend <= 1'b0;
		end else begin
			CMD_ACK_O <= wr | CMD_SEND_I;
			CML_RO_WRITE_O <= wr && ro_hit;
			// an eeprom read answers one cycle later than a register read
			rd_pend <= CMD_RD_I && CMD_CODE_I == `PMCB_CMD_EE_DATA && unlocked;
			CMD_RVALID_O <= 1'b0;
			if (rd_pend) begin
				CMD_RDATA_O <= EE_RDATA_I;
				CMD_RVALID_O <= 1'b1;
			end else if (CMD_RD_I && !(CMD_CODE_I == `PMCB_CMD_EE_DATA && unlocked)) begin
				CMD_RVALID_O <= 1'b1;
				// reserved and write-only codes answer zero
				case (CMD_CODE_I)
				`PMCB_CMD_OEM_A: CMD_RDATA_O <= oem_a;
				`PMCB_CMD_OEM_B: CMD_RDATA_O <= oem_b;
				`PMCB_CMD_TOOL: CMD_RDATA_O <= p ? tool_w1 : tool_w0;
				`PMCB_CMD_SPARE_P: CMD_RDATA_O <= p ? spare_p1 : spare_p0;
				`PMCB_CMD_SPARE_G: CMD_RDATA_O <= spare_g;
				`PMCB_CMD_INFO: CMD_RDATA_O <= INFO_VALUE;
				`PMCB_CMD_EE_UNLOCK: CMD_RDATA_O <= {15'h0000, unlocked};
				`PMCB_CMD_CHAN_OPT: CMD_RDATA_O <= {8'h00, p ? chan_opt1 : chan_opt0};
				`PMCB_CMD_GLOB_OPT: CMD_RDATA_O <= {8'h00, glob_opt};
				`PMCB_CMD_FLT_PROP: CMD_RDATA_O <= p ? prop1 : prop0;
				`PMCB_CMD_PWM_CFG: CMD_RDATA_O <= {8'h00, p ? pwm1 : pwm0};
				`PMCB_CMD_FLT_ACT: CMD_RDATA_O <= {8'h00, p ? fact1 : fact0};
				`PMCB_CMD_OT_ACT: CMD_RDATA_O <= {8'h00, `PMCB_VAL_OT_ACT};
				`PMCB_CMD_IOUT_PK: CMD_RDATA_O <= p ? ipk1 : ipk0;
				`PMCB_CMD_ADC_SEL: CMD_RDATA_O <= {8'h00, adc_sel};
				`PMCB_CMD_ADC_STAT: CMD_RDATA_O <= {8'h00, adc_stat};
				`PMCB_CMD_RETRY: CMD_RDATA_O <= p ? retry1 : retry0;
				`PMCB_CMD_RESTART: CMD_RDATA_O <= p ? restart1 : restart0;
				`PMCB_CMD_VOUT_PK: CMD_RDATA_O <= p ? vpk1 : vpk0;
				`PMCB_CMD_VIN_PK: CMD_RDATA_O <= vinpk;
				`PMCB_CMD_TEMP_PK: CMD_RDATA_O <= p ? tpk1 : tpk0;
				`PMCB_CMD_PADS: CMD_RDATA_O <= PAD_LEVELS_I;
				`PMCB_CMD_ADDR: CMD_RDATA_O <= {8'h00, addr};
				default: CMD_RDATA_O <= `PMCB_RST_ZERO16;
				endcase
			end
		end
	end
endmodule // pmcb_bank
`default_nettype wire

/* File: pmcb_bank_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmcb_map.vh"
module pmcb_bank_props (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic CMD_WR_I,
	input wire logic CMD_RD_I,
	input wire logic [7:0] CMD_CODE_I,
	input wire logic [15:0] CMD_WDATA_I,
	input wire logic [15:0] CMD_RDATA_O,
	input wire logic CMD_RVALID_O,
	input wire logic CMD_ACK_O,
	input wire logic [15:0] PAD_LEVELS_I,
	input wire logic STORE_ALL_I,
	input wire logic NV_STORE_O,
	input wire logic EE_WR_O,
	input wire logic EE_RD_O,
	input wire logic CML_RO_WRITE_O,
	input wire logic [6:0] BUS_ADDR_O
);
	// codes that only ever answer reads
	wire ro_code = (CMD_CODE_I == 8'hb6) || (CMD_CODE_I == 8'hd6) || (CMD_CODE_I == 8'hd7) ||
		(CMD_CODE_I >= 8'hdd && CMD_CODE_I <= 8'hdf) || (CMD_CODE_I == 8'he5);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	a_write_ack: assert property (CMD_WR_I |=> CMD_ACK_O) else $error("write not acked");
	a_ro_flag: assert property (CMD_WR_I && ro_code |=> CML_RO_WRITE_O) else $error("no ro flag");
	a_rw_no_flag: assert property (CMD_WR_I && !ro_code |=> !CML_RO_WRITE_O) else $error("bad ro flag");
	a_read_answer: assert property (
		CMD_RD_I && CMD_CODE_I != `PMCB_CMD_EE_DATA |=> CMD_RVALID_O)
		else $error("read not answered");
	a_pads_live: assert property (CMD_RD_I && CMD_CODE_I == `PMCB_CMD_PADS |=>
		CMD_RDATA_O == $past(PAD_LEVELS_I)) else $error("pad word wrong");
	a_ot_fixed: assert property (CMD_RD_I && CMD_CODE_I == `PMCB_CMD_OT_ACT |=>
		CMD_RDATA_O == {8'h00, `PMCB_VAL_OT_ACT}) else $error("ot action wrong");
	a_addr_update: assert property (CMD_WR_I && CMD_CODE_I == `PMCB_CMD_ADDR |=>
		BUS_ADDR_O == $past(CMD_WDATA_I[6:0])) else $error("bus address wrong");
	a_nv_pass: assert property (NV_STORE_O == STORE_ALL_I) else $error("store not passed");
	a_ee_rd_data: assert property (EE_RD_O |=> CMD_RVALID_O) else $error("ee read lost");
	a_ee_wr_cause: assert property (EE_WR_O |-> $past(CMD_WR_I) &&
		$past(CMD_CODE_I) == `PMCB_CMD_EE_DATA) else $error("stray ee write");
	c_ee_write: cover property (EE_WR_O);
	c_ro_write: cover property (CML_RO_WRITE_O);
	c_ee_read: cover property (EE_RD_O);
endmodule // pmcb_bank_props
bind pmcb_bank pmcb_bank_props i_props (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
	.CMD_WR_I(CMD_WR_I), .CMD_RD_I(CMD_RD_I), .CMD_CODE_I(CMD_CODE_I), .CMD_WDATA_I(CMD_WDATA_I),
	.CMD_RDATA_O(CMD_RDATA_O), .CMD_RVALID_O(CMD_RVALID_O), .CMD_ACK_O(CMD_ACK_O),
	.PAD_LEVELS_I(PAD_LEVELS_I), .STORE_ALL_I(STORE_ALL_I), .NV_STORE_O(NV_STORE_O),
	.EE_WR_O(EE_WR_O), .EE_RD_O(EE_RD_O), .CML_RO_WRITE_O(CML_RO_WRITE_O), .BUS_ADDR_O(BUS_ADDR_O));
`default_nettype wire

/* File: pmcb_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmcb_map.vh"
module pmcb_bank_tb;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, snd = 1'b0, page = 1'b0, tv = 1'b0;
	logic tch = 1'b0, av = 1'b0, sto = 1'b0, rso = 1'b0;
	logic [7:0] code = 8'h00, aid = 8'h00;
	logic [15:0] wdata = 16'h0000, ti = 16'h0000, tvo = 16'h0000, pads = 16'h0000, r;
	wire [15:0] rdata, ee_wd, ee_rd, fp0, fp1, rt0, rt1, rs0, rs1;
	wire rvalid, ack, ee_er, ee_w, ee_r, comm_memory_fault_status, nvs, nvr;
	wire [7:0] ee_a, fsel;
	wire [6:0] baddr;
	int fail_count = 0, check_count = 0, cyc = 0, ee_wr_seen = 0;
	logic [7:0] rc [12] = '{8'hb3, 8'hb4, 8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5, 8'hd6, 8'hd8,
		8'hdb, 8'hdc, 8'he6};
	logic [15:0] rv [12] = '{16'h0000, 16'h0000, 16'h001d, 16'h0021, 16'h6993, 16'h00c1,
		16'h00c0, 16'h00c0, 16'h0000, 16'hfabc, 16'hfbe8, 16'h004f};
	pmcb_bank #(.EE_AW(8), .INFO_VALUE(16'h5a5a)) i_pmcb_bank (.SYS_CLK_I(clk), .RESET_I(rst),
		.CMD_WR_I(wr), .CMD_RD_I(rd), .CMD_SEND_I(snd), .CMD_CODE_I(code), .CMD_PAGE_I(page),
		.CMD_WDATA_I(wdata), .CMD_RDATA_O(rdata), .CMD_RVALID_O(rvalid), .CMD_ACK_O(ack),
		.TEL_VALID_I(tv), .TEL_CHAN_I(tch), .TEL_IOUT_I(ti), .TEL_VOUT_I(tvo), .TEL_VIN_I(ti),
		.TEL_TEMP_I(ti), .ADC_CONV_VALID_I(av), .ADC_CONV_ID_I(aid), .PAD_LEVELS_I(pads),
		.STORE_ALL_I(sto), .RESTORE_ALL_I(rso), .NV_STORE_O(nvs), .NV_RESTORE_O(nvr),
		.EE_ERASE_O(ee_er), .EE_WR_O(ee_w), .EE_RD_O(ee_r), .EE_ADDR_O(ee_a), .EE_WDATA_O(ee_wd),
		.EE_RDATA_I(ee_rd), .CML_RO_WRITE_O(comm_memory_fault_status), .BUS_ADDR_O(baddr), .FAST_ADC_SEL_O(fsel),
		.FLT_PROP0_O(fp0), .FLT_PROP1_O(fp1), .RETRY0_O(rt0), .RETRY1_O(rt1),
		.RESTART0_O(rs0), .RESTART1_O(rs1));
	pmcb_ee_model #(.AW(8)) i_pmcb_ee_model (.clk_i(clk), .erase_i(ee_er), .wr_i(ee_w),
		.rd_i(ee_r), .addr_i(ee_a), .wdata_i(ee_wd), .rdata_o(ee_rd));
	// free-running clock
	always #5 clk = ~clk;
	// hang guard, well above the hundred or so cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (ee_w === 1'b1) ee_wr_seen++;
		if (cyc == 3000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	// one-cycle write or send strobe, launched off the falling edge
	task automatic cmd_wr(input logic s, input logic [7:0] c, input logic p, input logic [15:0] d);
		@(negedge clk);
		code = c;
		page = p;
		wdata = d;
		if (s) snd = 1'b1;
		else wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		snd = 1'b0;
	endtask
	task automatic cmd_rd(input logic [7:0] c, input logic p, output logic [15:0] d);
		@(negedge clk);
		code = c;
		page = p;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		for (int n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
		d = rdata;
	endtask
	task automatic tel(input logic ch, input logic [15:0] l11, input logic [15:0] l16);
		@(negedge clk);
		tch = ch;
		ti = l11;
		tvo = l16;
		tv = 1'b1;
		@(negedge clk);
		tv = 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int k = 0; k < 12; k++) begin
			cmd_rd(rc[k], 1'b0, r);
			chk("reset value", rv[k], r);
		end
		// peaks: l11 by real value, l16 unsigned, page 1 untouched
		tel(1'b0, 16'hf864, 16'h1000);
		tel(1'b0, 16'h003c, 16'h0800);
		tel(1'b0, 16'h0020, 16'h0c00);
		cmd_wr(1'b0, `PMCB_CMD_IOUT_PK, 1'b0, 16'h1111);
		chk("ro write flag", 16'h0001, {15'h0, comm_memory_fault_status});
		chk("ro write ack", 16'h0001, {15'h0, ack});
		cmd_rd(`PMCB_CMD_IOUT_PK, 1'b0, r);
		chk("iout peak", 16'h003c, r);
		cmd_rd(`PMCB_CMD_IOUT_PK, 1'b1, r);
		chk("iout peak page1", `PMCB_PK_L11_FLOOR, r);
		cmd_rd(`PMCB_CMD_VOUT_PK, 1'b0, r);
		chk("vout peak", 16'h1000, r);
		cmd_rd(`PMCB_CMD_VIN_PK, 1'b0, r);
		chk("vin peak", 16'h003c, r);
		cmd_rd(`PMCB_CMD_TEMP_PK, 1'b0, r);
		chk("temp peak", 16'h003c, r);
		cmd_wr(1'b1, `PMCB_CMD_CLR_PK, 1'b0, 16'h0000);
		cmd_rd(`PMCB_CMD_VOUT_PK, 1'b0, r);
		chk("vout cleared", `PMCB_PK_L16_FLOOR, r);
		tel(1'b0, 16'h0005, 16'h0100);
		cmd_rd(`PMCB_CMD_IOUT_PK, 1'b0, r);
		chk("iout after clear", 16'h0005, r);
		// channel 1 sample: 16 * 2^-1 beats the earlier input sample of 5
		tel(1'b1, 16'hf810, 16'h0200);
		cmd_rd(`PMCB_CMD_IOUT_PK, 1'b1, r);
		chk("iout peak page1", 16'hf810, r);
		cmd_rd(`PMCB_CMD_VOUT_PK, 1'b1, r);
		chk("vout peak page1", 16'h0200, r);
		cmd_rd(`PMCB_CMD_VIN_PK, 1'b0, r);
		chk("vin across exponents", 16'hf810, r);
		// paged words land on the right channel
		cmd_wr(1'b0, `PMCB_CMD_FLT_PROP, 1'b1, 16'habcd);
		cmd_wr(1'b0, `PMCB_CMD_RETRY, 1'b1, 16'h0123);
		cmd_wr(1'b0, `PMCB_CMD_RESTART, 1'b0, 16'h0456);
		chk("prop page0", 16'h6993, fp0);
		chk("prop page1", 16'habcd, fp1);
		chk("retry page0", 16'hfabc, rt0);
		chk("retry page1", 16'h0123, rt1);
		chk("restart page0", 16'h0456, rs0);
		chk("restart page1", 16'hfbe8, rs1);
		cmd_wr(1'b0, `PMCB_CMD_ADDR, 1'b0, 16'h0032);
		cmd_wr(1'b0, `PMCB_CMD_ADC_SEL, 1'b0, 16'h0005);
		chk("bus addr", 16'h0032, {9'h000, baddr});
		chk("adc select", 16'h0005, {8'h00, fsel});
		cmd_wr(1'b0, `PMCB_CMD_OEM_A, 1'b0, 16'hbeef);
		cmd_rd(`PMCB_CMD_OEM_A, 1'b0, r);
		chk("oem word", 16'hbeef, r);
		cmd_wr(1'b0, `PMCB_CMD_INFO, 1'b0, 16'h0000);
		cmd_rd(`PMCB_CMD_INFO, 1'b0, r);
		chk("info word", 16'h5a5a, r);
		@(negedge clk);
		av = 1'b1;
		aid = 8'h03;
		pads = 16'ha5c3;
		sto = 1'b1;
		rso = 1'b1;
		#1 chk("store pass", 16'h0001, {15'h0, nvs});
		chk("restore pass", 16'h0001, {15'h0, nvr});
		@(negedge clk);
		av = 1'b0;
		sto = 1'b0;
		rso = 1'b0;
		cmd_rd(`PMCB_CMD_ADC_STAT, 1'b0, r);
		chk("adc status", 16'h0003, r);
		cmd_rd(`PMCB_CMD_PADS, 1'b0, r);
		chk("pads", 16'ha5c3, r);
		// eeprom: locked accesses go nowhere, then erase and two-word burst
		cmd_wr(1'b0, `PMCB_CMD_EE_DATA, 1'b0, 16'h1357);
		cmd_rd(`PMCB_CMD_EE_DATA, 1'b0, r);
		chk("locked read", 16'h0000, r);
		chk("locked write", 16'h0000, 16'(ee_wr_seen));
		cmd_wr(1'b0, `PMCB_CMD_EE_UNLOCK, 1'b0, 16'h0001);
		cmd_wr(1'b0, `PMCB_CMD_EE_ERASE, 1'b0, 16'h0000);
		cmd_wr(1'b0, `PMCB_CMD_EE_DATA, 1'b0, 16'h1357);
		cmd_wr(1'b0, `PMCB_CMD_EE_DATA, 1'b0, 16'h2468);
		cmd_rd(`PMCB_CMD_EE_DATA, 1'b0, r);
		chk("ee word0", 16'h1357, i_pmcb_ee_model.mem[0]);
		chk("ee word1", 16'h2468, i_pmcb_ee_model.mem[1]);
		chk("ee read next", 16'hffff, r);
		close_out();
	end
endmodule // pmcb_bank_tb
`default_nettype wire

/* File: pmcb_ee_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmcb_ee_model #(
	parameter AW = 8
) (
	input wire logic clk_i,
	input wire logic erase_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	output var logic [15:0] rdata_o
);
	logic [15:0] mem [0:(1<<AW)-1];
	// read is combinational while the strobe is up, so the bank takes the word at the
	// edge that ends the strobe; otherwise the inverse shows, so a late sample is caught
	assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
	// erase fills with ones; a write lands at the strobed address
	always @(posedge clk_i) begin
		if (erase_i) begin
			for (int k = 0; k < (1 << AW); k++) mem[k] <= 16'hffff;
		end
		if (wr_i) mem[addr_i] <= wdata_i;
	end
endmodule // pmcb_ee_model
`default_nettype wire

/* File: pmcb_map.vh */
`ifndef PMCB_MAP_VH
`define PMCB_MAP_VH
// command codes of the manufacturer range
`define PMCB_CMD_OEM_A 8'hb0
`define PMCB_CMD_TOOL 8'hb1
`define PMCB_CMD_OEM_B 8'hb2
`define PMCB_CMD_SPARE_P 8'hb3
`define PMCB_CMD_SPARE_G 8'hb4
`define PMCB_CMD_INFO 8'hb6
`define PMCB_CMD_EE_UNLOCK 8'hbd
`define PMCB_CMD_EE_ERASE 8'hbe
`define PMCB_CMD_EE_DATA 8'hbf
`define PMCB_CMD_CHAN_OPT 8'hd0
`define PMCB_CMD_GLOB_OPT 8'hd1
`define PMCB_CMD_FLT_PROP 8'hd2
`define PMCB_CMD_PWM_CFG 8'hd4
`define PMCB_CMD_FLT_ACT 8'hd5
`define PMCB_CMD_OT_ACT 8'hd6
`define PMCB_CMD_IOUT_PK 8'hd7
`define PMCB_CMD_ADC_SEL 8'hd8
`define PMCB_CMD_ADC_STAT 8'hda
`define PMCB_CMD_RETRY 8'hdb
`define PMCB_CMD_RESTART 8'hdc
`define PMCB_CMD_VOUT_PK 8'hdd
`define PMCB_CMD_VIN_PK 8'hde
`define PMCB_CMD_TEMP_PK 8'hdf
`define PMCB_CMD_CLR_PK 8'he3
`define PMCB_CMD_PADS 8'he5
`define PMCB_CMD_ADDR 8'he6
// reset values, and the fixed over-temperature action byte
`define PMCB_RST_ZERO16 16'h0000
`define PMCB_RST_ZERO8 8'h00
`define PMCB_RST_CHAN_OPT 8'h1d
`define PMCB_RST_GLOB_OPT 8'h21
`define PMCB_RST_FLT_PROP 16'h6993
`define PMCB_RST_PWM_CFG 8'hc1
`define PMCB_RST_FLT_ACT 8'hc0
`define PMCB_VAL_OT_ACT 8'hc0
`define PMCB_RST_RETRY 16'hfabc
`define PMCB_RST_RESTART 16'hfbe8
`define PMCB_RST_ADDR 8'h4f
// peak floors: most negative linear word and zero unsigned
`define PMCB_PK_L11_FLOOR 16'h7c00
`define PMCB_PK_L16_FLOOR 16'h0000
// linear-word fields
`define PMCB_EXP_HI 15
`define PMCB_EXP_LO 11
`define PMCB_MAN_HI 10
// fraction bits of the fixed-point grid used to order linear words
`define PMCB_L11_FRAC 16
// memory fault bit in the comm status byte
`define PMCB_CML_RO_WRITE_BIT 6
`define PMCB_ADDR_MASK 8'h7f
`endif
